// File: rtl/branch_call_negate_exec.sv
// Four-phase execution of branch, call, negate and AND instructions
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns

// Functional notes
// - Zero-flag branch adds 2 plus twice signed offset to PC; flags untouched.
// - Taken branch costs a second idle cycle; untaken one has no Q4 PC write.
// - Call is two words: low target byte, then word tagged 1111 with high bits.
// - Call pushes its address plus 4, then loads 20-bit target into PC bits 20:1.
// - Call with save bit set copies work, status and bank into shadows.
// - Negate writes two's complement back and updates N, OV, C, DC, Z.
// - Access bit clear selects the access bank for the operand unless extended indexing applies.
// - Access bit set takes the operand bank from the bank select register.
// - Extended mode with access clear indexes offsets up to 95 from base.
// - Carry-flag branch jumps like the zero branch, else runs in sequence.
// - AND of work and byte goes to work or byte by direction bit; N, Z.
module branch_call_negate_exec (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [core_pkg::BUS_AW-1:0] regAddr,
    input wire logic [core_pkg::BUS_DW-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [core_pkg::BUS_DW-1:0] regRdData,
    // Program memory
    output logic [core_pkg::PC_W-1:0] pmAddr,
    output logic pmRead,
    input wire logic [core_pkg::IR_W-1:0] pmData,
    // Data memory
    output logic [core_pkg::DA_W-1:0] dmAddr,
    output logic dmRead,
    input wire logic [7:0] dmRdData,
    output logic dmWrite,
    output logic [7:0] dmWrData,
    // Index base for literal offset mode
    input wire logic [core_pkg::DA_W-1:0] indexBase,
    // Status
    output logic [core_pkg::PC_W-1:0] pcOut,
    output logic running
);

    // ==================================================================
    // State
    typedef struct packed {
        core_pkg::phase_t phase;
        core_pkg::exec_t ex;
        core_pkg::iclass_t ic;
        logic taken;
        logic [core_pkg::PC_W-1:0] pc;
        logic [core_pkg::IR_W-1:0] ir;
        logic [7:0] work;
        logic [core_pkg::ST_W-1:0] status;
        logic [core_pkg::BSR_W-1:0] bank_select_reg;
        logic [7:0] workShadow;
        logic [core_pkg::ST_W-1:0] statusShadow;
        logic [core_pkg::BSR_W-1:0] bankShadow;
        logic [core_pkg::PC_W-1:0] retTop;
        logic [1:0] ctrl;
        logic [7:0] operand;
        logic [core_pkg::PC_W-1:0] pmAddr;
        logic pmRead;
        logic [core_pkg::DA_W-1:0] dmAddr;
        logic dmRead;
        logic dmWrite;
        logic [7:0] dmWrData;
        logic [core_pkg::BUS_DW-1:0] rdData;
        logic running;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    exec_if ex ();

    operand_addr u_addr (
        .ex(ex)
    );

    byte_alu u_alu (
        .ex(ex)
    );

    // ==================================================================
    // Decode
    function automatic core_pkg::iclass_t decode(input logic [core_pkg::IR_W-1:0] w);
        if (w[15:8] == core_pkg::OP_BR_ZERO) begin
            decode = core_pkg::IC_BZ;
        end else if (w[15:8] == core_pkg::OP_BR_CARRY) begin
            decode = core_pkg::IC_BC;
        end else if (w[15:9] == core_pkg::OP_CALL) begin
            decode = core_pkg::IC_CALL;
        end else if (w[15:9] == core_pkg::OP_NEGATE) begin
            decode = core_pkg::IC_NEG;
        end else if (w[15:10] == core_pkg::OP_AND) begin
            decode = core_pkg::IC_AND;
        end else begin
            // Zero word, stray second word and anything foreign fall here
            decode = core_pkg::IC_NOP;
        end
    endfunction

    logic [core_pkg::IR_W-1:0] decWord;
    core_pkg::iclass_t decClass;
    logic [core_pkg::PC_W-1:0] branchOfs;
    logic [core_pkg::PC_W-1:0] callTarget;
    logic hold;

    assign decWord = (s_r.phase == core_pkg::PH_Q1) ? pmData : s_r.ir;
    assign decClass = decode(pmData);
    // Sign-extended offset doubled
    assign branchOfs = {{12{s_r.ir[7]}}, s_r.ir[7:0], 1'b0};
    assign callTarget = {pmData[11:0], s_r.ir[7:0], 1'b0};
    // Parked at the start of an idle cycle while stopped
    assign hold = !s_r.ctrl[core_pkg::CTRL_RUN] && s_r.phase == core_pkg::PH_Q1
                  && s_r.ex == core_pkg::EX_FLUSH;

    assign ex.ir = decWord;
    assign ex.extEn = s_r.ctrl[core_pkg::CTRL_EXT];
    assign ex.bank_select_reg = s_r.bank_select_reg;
    assign ex.indexBase = indexBase;
    assign ex.operand = s_r.operand;
    assign ex.work = s_r.work;
    assign ex.isNeg = (s_r.ic == core_pkg::IC_NEG);
    assign ex.flagsIn = s_r.status;

    // ==================================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.pmRead = 1'b0;
        s_nxt.dmRead = 1'b0;
        s_nxt.dmWrite = 1'b0;
        s_nxt.rdData = '0;
        s_nxt.running = !hold;

        // Register reads: data stands the cycle after the strobe
        if (regRdStb) begin
            if (regAddr == core_pkg::REG_CTRL) begin
                s_nxt.rdData = {30'h0, s_r.ctrl};
            end else if (regAddr == core_pkg::REG_WORK) begin
                s_nxt.rdData = {24'h0, s_r.work};
            end else if (regAddr == core_pkg::REG_STATUS) begin
                s_nxt.rdData = {27'h0, s_r.status};
            end else if (regAddr == core_pkg::REG_BANK) begin
                s_nxt.rdData = {28'h0, s_r.bank_select_reg};
            end else if (regAddr == core_pkg::REG_PC) begin
                s_nxt.rdData = {11'h0, s_r.pc};
            end else if (regAddr == core_pkg::REG_RET_TOP) begin
                s_nxt.rdData = {11'h0, s_r.retTop};
            end else if (regAddr == core_pkg::REG_SHADOW) begin
                s_nxt.rdData = {15'h0, s_r.bankShadow, s_r.statusShadow, s_r.workShadow};
            end else begin
                s_nxt.rdData = '0;
            end
        end

        // Software writes; execution below overrides in the same cycle
        if (regWrStb) begin
            if (regAddr == core_pkg::REG_CTRL) begin
                s_nxt.ctrl = regWrData[1:0];
            end else if (regAddr == core_pkg::REG_WORK) begin
                s_nxt.work = regWrData[7:0];
            end else if (regAddr == core_pkg::REG_STATUS) begin
                s_nxt.status = regWrData[core_pkg::ST_W-1:0];
            end else if (regAddr == core_pkg::REG_BANK) begin
                s_nxt.bank_select_reg = regWrData[core_pkg::BSR_W-1:0];
            end
        end

        if (!hold) begin
            s_nxt.phase = core_pkg::phase_t'(s_r.phase + 2'h1);
            case (s_r.phase)
                core_pkg::PH_Q1: begin
                    if (s_r.ex == core_pkg::EX_NORMAL) begin
                        s_nxt.ir = pmData;
                        s_nxt.ic = decClass;
                        s_nxt.taken = 1'b0;
                        if (decClass == core_pkg::IC_NEG || decClass == core_pkg::IC_AND) begin
                            s_nxt.dmAddr = ex.opAddr;
                            s_nxt.dmRead = 1'b1;
                        end
                        if (decClass == core_pkg::IC_CALL) begin
                            // Second word arrives for Q4
                            s_nxt.pmAddr = s_r.pc + core_pkg::PC_STEP;
                            s_nxt.pmRead = 1'b1;
                        end
                    end
                end
                core_pkg::PH_Q2: begin
                    if (s_r.ex == core_pkg::EX_NORMAL && s_r.ic == core_pkg::IC_CALL) begin
                        s_nxt.retTop = s_r.pc + core_pkg::CALL_RET_OFS;
                        if (s_r.ir[core_pkg::SAVE_BIT]) begin
                            s_nxt.workShadow = s_r.work;
                            s_nxt.statusShadow = s_r.status;
                            s_nxt.bankShadow = s_r.bank_select_reg;
                        end
                    end
                end
                core_pkg::PH_Q3: begin
                    if (s_r.ex == core_pkg::EX_FLUSH) begin
                        // Refetch at the new PC during the idle cycle
                        s_nxt.pmAddr = s_r.pc;
                        s_nxt.pmRead = 1'b1;
                    end else begin
                        if (s_r.ic == core_pkg::IC_NEG || s_r.ic == core_pkg::IC_AND) begin
                            s_nxt.operand = dmRdData;
                        end
                        if (s_r.ic == core_pkg::IC_BZ) begin
                            s_nxt.taken = s_r.status[core_pkg::ST_Z];
                        end else if (s_r.ic == core_pkg::IC_BC) begin
                            s_nxt.taken = s_r.status[core_pkg::ST_C];
                        end
                        // Sequential advance happens at fetch, not in Q4
                        if (s_r.ic != core_pkg::IC_CALL &&
                            !((s_r.ic == core_pkg::IC_BZ && s_r.status[core_pkg::ST_Z]) ||
                              (s_r.ic == core_pkg::IC_BC && s_r.status[core_pkg::ST_C]))) begin
                            s_nxt.pc = s_r.pc + core_pkg::PC_STEP;
                            s_nxt.pmAddr = s_r.pc + core_pkg::PC_STEP;
                            s_nxt.pmRead = 1'b1;
                        end
                    end
                end
                default: begin
                    if (s_r.ex == core_pkg::EX_FLUSH) begin
                        s_nxt.ex = core_pkg::EX_NORMAL;
                    end else begin
                        case (s_r.ic)
                            core_pkg::IC_BZ, core_pkg::IC_BC: begin
                                if (s_r.taken) begin
                                    s_nxt.pc = s_r.pc + core_pkg::PC_STEP + branchOfs;
                                    s_nxt.ex = core_pkg::EX_FLUSH;
                                end
                            end
                            core_pkg::IC_CALL: begin
                                s_nxt.pc = callTarget;
                                s_nxt.ex = core_pkg::EX_FLUSH;
                            end
                            core_pkg::IC_NEG: begin
                                s_nxt.dmWrite = 1'b1;
                                s_nxt.dmWrData = ex.result;
                                s_nxt.status = ex.flagsOut;
                            end
                            core_pkg::IC_AND: begin
                                if (s_r.ir[core_pkg::DEST_BIT]) begin
                                    s_nxt.dmWrite = 1'b1;
                                    s_nxt.dmWrData = ex.result;
                                end else begin
                                    s_nxt.work = ex.result;
                                end
                                s_nxt.status = ex.flagsOut;
                            end
                            default: begin
                            end
                        endcase
                    end
                    // Stopping takes effect at a cycle boundary
                    if (!s_nxt.ctrl[core_pkg::CTRL_RUN]) begin
                        s_nxt.ex = core_pkg::EX_FLUSH;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
            s_r.phase <= core_pkg::PH_Q1;
            s_r.ex <= core_pkg::EX_FLUSH;
            s_r.ic <= core_pkg::IC_NOP;
            s_r.pc <= core_pkg::PC_RESET;
            s_r.ctrl <= core_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign pmAddr = s_r.pmAddr;
    assign pmRead = s_r.pmRead;
    assign dmAddr = s_r.dmAddr;
    assign dmRead = s_r.dmRead;
    assign dmWrite = s_r.dmWrite;
    assign dmWrData = s_r.dmWrData;
    assign pcOut = s_r.pc;
    assign running = s_r.running;

endmodule // branch_call_negate_exec

// File: rtl/byte_alu.sv
// Negate and AND datapath with status flag generation
`timescale 1ns/1ns
module byte_alu (
    exec_if.alu ex
);
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] res;

    assign diff = 9'h000 - {1'b0, ex.operand};
    assign nib = 5'h00 - {1'b0, ex.operand[3:0]};

    always_comb begin
        ex.flagsOut = ex.flagsIn;
        if (ex.isNeg) begin
            res = diff[7:0];
            // Borrow-style carries: set only when nothing was borrowed
            ex.flagsOut[core_pkg::ST_C] = ~diff[8];
            ex.flagsOut[core_pkg::ST_DC] = ~nib[4];
            ex.flagsOut[core_pkg::ST_OV] = ex.operand[7] & res[7];
        end else begin
            res = ex.work & ex.operand;
        end
        ex.flagsOut[core_pkg::ST_N] = res[7];
        ex.flagsOut[core_pkg::ST_Z] = (res == 8'h00);
        ex.result = res;
    end
endmodule // byte_alu

// File: rtl/core_pkg.sv
// Shared constants and types for the branch, call and negate execution block
package core_pkg;

    // ==================================================================
    // Widths
    localparam int PC_W = 21;
    localparam int IR_W = 16;
    localparam int DA_W = 12;
    localparam int BSR_W = 4;
    localparam int ST_W = 5;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;

    // ==================================================================
    // Opcode fields
    localparam logic [7:0] OP_BR_ZERO = 8'hE0;
    localparam logic [7:0] OP_BR_CARRY = 8'hE2;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [6:0] OP_NEGATE = 7'h36;
    localparam logic [5:0] OP_AND = 6'h05;
    localparam logic [3:0] OP_SECOND = 4'hF;
    localparam int SAVE_BIT = 8;
    localparam int ACCESS_BIT = 8;
    localparam int DEST_BIT = 9;

    // ==================================================================
    // Program counter steps
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] CALL_RET_OFS = 21'h000004;

    // ==================================================================
    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;

    // ==================================================================
    // Access bank layout
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [BSR_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [BSR_W-1:0] ACCESS_SFR_BANK = 4'hF;

    // ==================================================================
    // Register map
    localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [BUS_AW-1:0] REG_WORK = 8'h04;
    localparam logic [BUS_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [BUS_AW-1:0] REG_BANK = 8'h0C;
    localparam logic [BUS_AW-1:0] REG_PC = 8'h10;
    localparam logic [BUS_AW-1:0] REG_RET_TOP = 8'h14;
    localparam logic [BUS_AW-1:0] REG_SHADOW = 8'h18;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

    // ==================================================================
    // Enumerations
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
    typedef enum logic {EX_NORMAL, EX_FLUSH} exec_t;
    typedef enum logic [2:0] {IC_NOP, IC_BZ, IC_BC, IC_CALL, IC_NEG, IC_AND} iclass_t;

endpackage

// File: rtl/exec_if.sv
// Signals between the sequencer, the operand address unit and the ALU
`timescale 1ns/1ns
interface exec_if;
    logic [core_pkg::IR_W-1:0] ir;
    logic extEn;
    logic [core_pkg::BSR_W-1:0] bank_select_reg;
    logic [core_pkg::DA_W-1:0] indexBase;
    logic [core_pkg::DA_W-1:0] opAddr;
    logic [7:0] operand;
    logic [7:0] work;
    logic isNeg;
    logic [core_pkg::ST_W-1:0] flagsIn;
    logic [7:0] result;
    logic [core_pkg::ST_W-1:0] flagsOut;

    modport ctrl (output ir, extEn, bank_select_reg, indexBase, operand, work, isNeg, flagsIn,
                  input opAddr, result, flagsOut);
    modport agen (input ir, extEn, bank_select_reg, indexBase, output opAddr);
    modport alu (input operand, work, isNeg, flagsIn, output result, flagsOut);
endinterface

// File: rtl/operand_addr.sv
// Data-memory operand address for byte instructions
`timescale 1ns/1ns
module operand_addr (
    exec_if.agen ex
);
    logic [7:0] f;
    logic accessSel;

    assign f = ex.ir[7:0];
    assign accessSel = ex.ir[core_pkg::ACCESS_BIT];

    always_comb begin
        if (accessSel) begin
            ex.opAddr = {ex.bank_select_reg, f};
        end else if (ex.extEn && f <= core_pkg::INDEX_LIMIT) begin
            // Index base plus literal offset; wraps inside data space
            ex.opAddr = ex.indexBase + {4'h0, f};
        end else if (f <= core_pkg::INDEX_LIMIT) begin
            ex.opAddr = {core_pkg::ACCESS_LOW_BANK, f};
        end else begin
            ex.opAddr = {core_pkg::ACCESS_SFR_BANK, f};
        end
    end
endmodule // operand_addr

// File: test/exec_props.sv
// Port-level checker for the branch, call and negate execution block
`timescale 1ns/1ns
module exec_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [core_pkg::BUS_AW-1:0] regAddr,
    input wire logic [core_pkg::BUS_DW-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [core_pkg::BUS_DW-1:0] regRdData,
    // Memories and status
    input wire logic [core_pkg::PC_W-1:0] pmAddr,
    input wire logic pmRead,
    input wire logic [core_pkg::DA_W-1:0] dmAddr,
    input wire logic dmRead,
    input wire logic dmWrite,
    input wire logic [core_pkg::PC_W-1:0] pcOut,
    input wire logic running
);
    // ==========================================================
    // Software-only fields
    logic [1:0] ctrlM_r;
    logic [core_pkg::BSR_W-1:0] bankM_r;
    logic mapped;
    assign mapped = regAddr <= 8'h18 && regAddr[1:0] == 2'h0;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrlM_r <= core_pkg::CTRL_RESET;
            bankM_r <= 4'h0;
        end else if (regWrStb && regAddr == core_pkg::REG_CTRL) begin
            ctrlM_r <= regWrData[1:0];
        end else if (regWrStb && regAddr == core_pkg::REG_BANK) begin
            bankM_r <= regWrData[core_pkg::BSR_W-1:0];
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Assertions
    rdata_idle_a: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
        else $error("stray read data");
    rdata_unmapped_a: assert property (regRdStb && !mapped |=> regRdData == 32'h0)
        else $error("unmapped read data");
    ctrl_read_a: assert property (regRdStb && regAddr == core_pkg::REG_CTRL |=> regRdData == 32'($past(ctrlM_r)))
        else $error("ctrl readback");
    bank_read_a: assert property (regRdStb && regAddr == core_pkg::REG_BANK |=> regRdData == 32'($past(bankM_r)))
        else $error("bank readback");
    pc_read_a: assert property (regRdStb && regAddr == core_pkg::REG_PC |=> regRdData == 32'($past(pcOut)))
        else $error("pc readback");
    fetch_addr_a: assert property (pmRead |-> pmAddr == pcOut || pmAddr == pcOut + core_pkg::PC_STEP)
        else $error("fetch address");
    fetch_pulse_a: assert property (pmRead |=> !pmRead)
        else $error("fetch pulse");
    rmw_same_a: assert property (dmWrite |-> $past(dmRead, 3) && $past(dmAddr, 3) == dmAddr)
        else $error("write address");
    parked_quiet_a: assert property (!running |-> !pmRead && !dmRead && !dmWrite)
        else $error("parked activity");
    stop_bound_a: assert property (regWrStb && regAddr == core_pkg::REG_CTRL && !regWrData[0] |=> ##[0:7] !running)
        else $error("no park");
endmodule // exec_props

bind branch_call_negate_exec exec_props props (.*);

// File: test/mem_model.sv
// Program and data memory model facing the execution block
`timescale 1ns/1ns
module mem_model (
    // Clock
    input wire logic mclk,
    // Program memory
    input wire logic [core_pkg::PC_W-1:0] pmAddr,
    input wire logic pmRead,
    output logic [core_pkg::IR_W-1:0] pmData,
    // Data memory
    input wire logic [core_pkg::DA_W-1:0] dmAddr,
    input wire logic dmRead,
    output logic [7:0] dmRdData,
    input wire logic dmWrite,
    input wire logic [7:0] dmWrData
);
    // ==========================================================
    // Program space folds onto 1K words
    logic [15:0] pmem [1024];
    logic [7:0] dmem [4096];
    initial begin
        foreach (pmem[i]) pmem[i] = 16'h0000;
        pmData = 16'h0000;
        dmRdData = 8'h00;
    end
    // Data read byte toggles outside its slot to expose late samples; pmData holds
    always @(posedge mclk) begin
        if (pmRead) begin
            pmData <= pmem[pmAddr[10:1]];
        end
        dmRdData <= dmRead ? dmem[dmAddr] : ~dmRdData;
        if (dmWrite) begin
            dmem[dmAddr] <= dmWrData;
        end
    end
endmodule // mem_model

// File: test/test_branch_call_negate_exec.sv
// Self-checking bench for the branch, call and negate execution block
`timescale 1ns/1ns
module test_branch_call_negate_exec;
    logic mclk, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, pmRead, dmRead, dmWrite, running;
    logic [7:0] regAddr = 8'h00, dmRdData, dmWrData;
    logic [31:0] regWrData = 32'h0, regRdData;
    logic [20:0] pmAddr, pcOut;
    logic [15:0] pmData;
    logic [11:0] dmAddr, indexBase = 12'h000;
    int miscompares = 0;
    int check_count = 0;
    int seed = 70;

    mem_model pm (.mclk(mclk), .pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData), .dmAddr(dmAddr),
        .dmRead(dmRead), .dmRdData(dmRdData), .dmWrite(dmWrite), .dmWrData(dmWrData));
    branch_call_negate_exec dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .pmAddr(pmAddr), .pmRead(pmRead),
        .pmData(pmData), .dmAddr(dmAddr), .dmRead(dmRead), .dmRdData(dmRdData), .dmWrite(dmWrite),
        .dmWrData(dmWrData), .indexBase(indexBase), .pcOut(pcOut), .running(running));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Bus tasks and comparisons
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask
    task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1;
        check(what, exp, regRdData);
    endtask
    task automatic wait_pc(input logic [20:0] target);
        for (int n = 0; pcOut !== target && n < 80; n++) begin
            @(posedge mclk);
            #1;
        end
        check("pc", target, pcOut);
    endtask
    // Six leading no-ops leave room to load registers before word 6 runs
    task automatic start(input logic [15:0] w6, input logic [15:0] w7, input logic [1:0] ctl,
                         input logic [7:0] w, input logic [4:0] st, input logic [3:0] bank);
        rst <= 1'b1;
        pm.pmem[1] = {4'hF, 12'($random(seed))};
        pm.pmem[3] = {4'hF, 12'($random(seed))};
        pm.pmem[6] = w6;
        pm.pmem[7] = w7;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        reg_write(core_pkg::REG_CTRL, 32'(ctl));
        reg_write(core_pkg::REG_WORK, 32'(w));
        reg_write(core_pkg::REG_STATUS, 32'(st));
        reg_write(core_pkg::REG_BANK, 32'(bank));
    endtask
    function automatic logic [31:0] neg_flags(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00 - v;
        return {27'h0, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
    endfunction

    task automatic results();
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] v, f, w, r;
        logic [4:0] st;
        logic [3:0] bank;
        logic [11:0] ib, addr;
        logic [15:0] instr;
        logic [19:0] k;
        logic [20:0] tgt, pcSeen;
        logic acc, ext, tk;
        int n, cyc;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) if (i != 4) expect_reg("reset value", 8'(i * 4), (i == 0) ? 32'h1 : 32'h0);
        reg_write(core_pkg::REG_RET_TOP, 32'hFFFFFFFF);
        expect_reg("read only", core_pkg::REG_RET_TOP, 32'h0);
        reg_write(core_pkg::REG_BANK, 32'hFFFFFFFF);
        expect_reg("bank width", core_pkg::REG_BANK, 32'hF);
        // Negate per addressing mode, AND per destination
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($random(seed));
            f = $random(seed);
            w = $random(seed);
            st = $random(seed);
            bank = $random(seed);
            ib = $random(seed);
            if (i == 2) f = f % 8'h60;
            if (i == 4) f = 8'h5F;
            if (i == 3 || i == 5) f[7] = 1'b1;
            acc = (i < 2 || i > 5);
            ext = (i == 4 || i == 5);
            addr = acc ? {bank, f} : (f > 8'h5F) ? {4'hF, f} : ext ? ib + 12'(f) : 12'(f);
            instr = (i < 6) ? {core_pkg::OP_NEGATE, acc, f} : {core_pkg::OP_AND, i == 7, acc, f};
            indexBase <= ib;
            start(instr, 16'h0000, {ext, 1'b1}, w, st, bank);
            pm.dmem[addr] = v;
            wait_pc(21'h000010);
            r = (i < 6) ? 8'h00 - v : w & v;
            check("data byte", (i == 6) ? 32'(v) : 32'(r), 32'(pm.dmem[addr]));
            expect_reg("work", core_pkg::REG_WORK, (i == 6) ? 32'(r) : 32'(w));
            expect_reg("status", core_pkg::REG_STATUS, (i < 6) ? neg_flags(v) :
                {27'h0, r[7], st[3], r == 8'h00, st[1:0]});
        end
        // Zero and carry branches, taken and not
        for (int j = 0; j < 4; j++) begin
            n = (j == 0) ? -128 : (j == 1) ? 127 : $random(seed) & 63;
            tk = (j < 2);
            st = $random(seed);
            st[core_pkg::ST_Z] = (j % 2) ? !tk : tk;
            st[core_pkg::ST_C] = (j % 2) ? tk : !tk;
            tgt = tk ? 14 + 2 * n : 14;
            start({(j % 2) ? core_pkg::OP_BR_CARRY : core_pkg::OP_BR_ZERO, n[7:0]}, 16'h0000, 2'h1, w, st, bank);
            wait_pc(21'h00000C);
            for (cyc = 0; pcOut === 21'h00000C && cyc < 20; cyc++) begin
                @(posedge mclk);
                #1;
            end
            check("cycles", tk ? 5 : 4, cyc);
            check("target", 32'(tgt), 32'(pcOut));
            expect_reg("status", core_pkg::REG_STATUS, 32'(st));
        end
        // Calls without and with the shadow save
        for (int s = 0; s < 2; s++) begin
            k = 20'($random(seed)) | 20'h00200;
            w = $random(seed);
            st = $random(seed);
            bank = $random(seed);
            start({core_pkg::OP_CALL, s == 1, k[7:0]}, {core_pkg::OP_SECOND, k[19:8]}, 2'h1, w, st, bank);
            wait_pc({k, 1'b0});
            expect_reg("return top", core_pkg::REG_RET_TOP, 32'h10);
            expect_reg("shadows", core_pkg::REG_SHADOW, s ? {15'h0, bank, st, w} : 32'h0);
            expect_reg("status", core_pkg::REG_STATUS, 32'(st));
        end
        // Park and restart
        reg_write(core_pkg::REG_CTRL, 32'h0);
        repeat (10) @(posedge mclk);
        #1;
        check("running", 32'h0, 32'(running));
        pcSeen = pcOut;
        repeat (8) @(posedge mclk);
        #1;
        check("parked pc", 32'(pcSeen), 32'(pcOut));
        reg_write(core_pkg::REG_CTRL, 32'h1);
        repeat (6) @(posedge mclk);
        #1;
        check("running", 32'h1, 32'(running));
        results();
    end
endmodule // test_branch_call_negate_exec
